// ---- rtl/sar_ctrl_consts.svh ----
// Timing counts and field positions for the converter control block
`ifndef SAR_CTRL_CONSTS_SVH
`define SAR_CTRL_CONSTS_SVH
`define RES_BITS 16
`define CLK_NS 40
`define ACQ_NS 400
`define ACQ_CYC ((`ACQ_NS + `CLK_NS - 1) / `CLK_NS)
`define CONV_NS 1600
`define CONV_CYC ((`CONV_NS + `CLK_NS - 1) / `CLK_NS)
`define SHARED_BIT 11
`define HIGH_LSB 12
`define HIGH_MSB 15
`define MCLK_DIV 4
`endif

// ---- rtl/sar_ctrl_pkg.sv ----
// Types shared by the converter control block
package sar_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_ACQ = 2'b00,
    ST_WAIT_EDGE = 2'b01,
    ST_CONV = 2'b10,
    ST_IDLE_PD = 2'b11
  } conv_state_e;

  typedef struct packed {
    logic serial_parallel_select;
    logic clock_source_select;
    logic power_down_request;
  } mode_cfg_s;

  typedef struct packed {
    logic [15:0] data;
    logic [15:0] oe;
  } data_bus_s;
endpackage

// ---- rtl/pin_sync.sv ----
// Three-stage synchroniser; a change counts once stages two and three agree
module pin_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Reset to the pin's idle level, so no false select or edge follows reset
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      o_level <= INIT;
    end else if (i_ce) begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule

// ---- rtl/sar_adc_conversion_control.sv ----
// Conversion control: start modes, busy, output gating, serial shift, read error
// Overview of operation
// - Shared pin is parallel bit 11 when parallel
// - Serial slave mode: shared pin is read error
// - Unfinished slave read at conversion end: discard, pulse
// - Bits 12 to 15 outputs in both modes, enabled only while select and read low
// - Busy high from start until result latched
// - Bus enabled only while select and read low, except shared pin always driven in slave mode
// - Chip select gates external serial clock
// - Reset clears sequencer and read state, keeps result, aborts conversion
// - Power-down stops conversions after current one
// - Start high after acquisition: wait falling edge
// - Start low after acquisition: convert immediately
// - Serial select repurposes shared pins as serial
// - Clock select low internal clock, high external
// - Result shifted out most significant bit first
`include "sar_ctrl_consts.svh"
module sar_adc_conversion_control
  import sar_ctrl_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_reset,
  // Host control pins
  input wire logic i_convert_start_n,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire mode_cfg_s i_cfg,
  input wire logic i_sclk,
  // Converted value from the analog core
  input wire logic [15:0] i_sar_result,
  // Status
  output logic o_busy,
  output logic o_hold,
  output logic o_powered_down,
  // Data pins
  output logic [15:0] o_data,
  output logic [15:0] o_data_oe,
  output logic o_sclk,
  output logic o_sclk_oe
);
  localparam logic [7:0] ACQ_CYC = 8'(`ACQ_CYC);
  localparam logic [7:0] CONV_CYC = 8'(`CONV_CYC);
  localparam logic [7:0] MCLK_DIV = 8'(`MCLK_DIV);
  localparam int SHARED = `SHARED_BIT;

  conv_state_e state_q;
  logic [7:0] cnt_q;
  logic [15:0] shreg_q;
  logic [4:0] bits_left_q;
  logic read_active_q;
  logic err_q;
  logic done_pulse_q;
  logic [7:0] mdiv_q;
  logic mclk_q;
  logic mclk_prev_q;
  logic start_n_s;
  logic cs_n_s;
  logic rd_n_s;
  logic sclk_s;
  logic start_prev_q;
  logic sclk_prev_q;
  logic rst_s;
  logic ser_sel;
  logic slave;
  logic bus_en;
  logic start_fall;
  logic shift_edge;
  data_bus_s bus_d;

  pin_sync #(.INIT(1'b1)) u_sync_start (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_pin(i_convert_start_n), .o_level(start_n_s));
  pin_sync #(.INIT(1'b1)) u_sync_cs (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_pin(i_cs_n), .o_level(cs_n_s));
  pin_sync #(.INIT(1'b1)) u_sync_rd (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_pin(i_rd_n), .o_level(rd_n_s));
  pin_sync #(.INIT(1'b0)) u_sync_sclk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_pin(i_sclk), .o_level(sclk_s));
  pin_sync #(.INIT(1'b0)) u_sync_rst (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_pin(i_reset), .o_level(rst_s));

  assign ser_sel = i_cfg.serial_parallel_select;
  assign slave = ser_sel & i_cfg.clock_source_select;
  assign bus_en = !cs_n_s && !rd_n_s;
  // Start sync and its delay flop both reset high; a fall during acquisition is ignored
  assign start_fall = start_prev_q && !start_n_s;
  // External clock only counts while selected
  assign shift_edge = slave ? (!cs_n_s && sclk_s && !sclk_prev_q)
                            : (mclk_q && !mclk_prev_q && !cs_n_s);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      mclk_prev_q <= 1'b0;
    end else if (i_ce) begin
      start_prev_q <= start_n_s;
      sclk_prev_q <= sclk_s;
      mclk_prev_q <= mclk_q;
    end
  end

  // Conversion sequencer
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_ACQ;
      cnt_q <= 8'h00;
      done_pulse_q <= 1'b0;
    end else if (i_ce) begin
      done_pulse_q <= 1'b0;
      if (rst_s) begin
        state_q <= ST_ACQ;
        cnt_q <= 8'h00;
      end else begin
        unique case (state_q)
          ST_ACQ: begin
            if (cnt_q < ACQ_CYC - 8'h01) begin
              cnt_q <= cnt_q + 8'h01;
            end else if (i_cfg.power_down_request) begin
              state_q <= ST_IDLE_PD;
            end else if (!start_n_s) begin
              state_q <= ST_CONV;
              cnt_q <= 8'h00;
            end else begin
              state_q <= ST_WAIT_EDGE;
            end
          end
          ST_WAIT_EDGE: begin
            if (i_cfg.power_down_request) begin
              state_q <= ST_IDLE_PD;
            end else if (start_fall) begin
              state_q <= ST_CONV;
              cnt_q <= 8'h00;
            end
          end
          ST_CONV: begin
            if (cnt_q < CONV_CYC - 8'h01) begin
              cnt_q <= cnt_q + 8'h01;
            end else begin
              // Power-down waits here until the running conversion ends
              state_q <= ST_ACQ;
              cnt_q <= 8'h00;
              done_pulse_q <= 1'b1;
            end
          end
          ST_IDLE_PD: begin
            if (!i_cfg.power_down_request) begin
              state_q <= ST_ACQ;
              cnt_q <= 8'h00;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
      o_hold <= 1'b0;
      o_powered_down <= 1'b0;
    end else if (i_ce) begin
      o_busy <= !rst_s && (state_q == ST_CONV);
      o_hold <= !rst_s && (state_q == ST_CONV);
      o_powered_down <= (state_q == ST_IDLE_PD);
    end
  end

  // Internal master serial clock
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mdiv_q <= 8'h00;
      mclk_q <= 1'b0;
    end else if (i_ce) begin
      if (!slave && read_active_q) begin
        if (mdiv_q == MCLK_DIV - 8'h01) begin
          mdiv_q <= 8'h00;
          mclk_q <= !mclk_q;
        end else begin
          mdiv_q <= mdiv_q + 8'h01;
        end
      end else begin
        mdiv_q <= 8'h00;
        mclk_q <= 1'b0;
      end
    end
  end

  // Shift register, read tracking, read error
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shreg_q <= 16'h0000;
      bits_left_q <= 5'h00;
      read_active_q <= 1'b0;
      err_q <= 1'b0;
    end else if (i_ce) begin
      err_q <= 1'b0;
      if (rst_s) begin
        bits_left_q <= 5'h00;
        read_active_q <= 1'b0;
      end else if (done_pulse_q) begin
        // Latching the new word discards a half-read one
        shreg_q <= i_sar_result;
        bits_left_q <= 5'h10;
        read_active_q <= 1'b0;
        err_q <= slave && read_active_q && (bits_left_q != 5'h00);
      end else if (ser_sel && bits_left_q != 5'h00 && bus_en) begin
        read_active_q <= 1'b1;
        if (shift_edge) begin
          shreg_q <= {shreg_q[14:0], 1'b0};
          bits_left_q <= bits_left_q - 5'h01;
          if (bits_left_q == 5'h01) begin
            read_active_q <= 1'b0;
          end
        end
      end
    end
  end

  always_comb begin
    bus_d.data = 16'h0000;
    bus_d.oe = 16'h0000;
    if (!ser_sel) begin
      bus_d.data = shreg_q;
      bus_d.oe = {16{bus_en}};
    end else begin
      bus_d.data[15:`HIGH_LSB] = shreg_q[15:`HIGH_LSB];
      bus_d.oe[15:`HIGH_LSB] = {4{bus_en}};
      bus_d.data[8] = shreg_q[15];
      bus_d.oe[8] = bus_en;
      if (slave) begin
        bus_d.data[SHARED] = err_q;
        bus_d.oe[SHARED] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= 16'h0000;
      o_data_oe <= 16'h0000;
      o_sclk <= 1'b0;
      o_sclk_oe <= 1'b0;
    end else if (i_ce) begin
      o_data <= bus_d.data;
      o_data_oe <= bus_d.oe;
      o_sclk <= mclk_q;
      o_sclk_oe <= ser_sel && !slave;
    end
  end

  // Checks
  sequence s_acq_done_low;
    i_ce && state_q == ST_ACQ && cnt_q == ACQ_CYC - 8'h01 && !start_n_s &&
      !i_cfg.power_down_request && !rst_s;
  endsequence
  property p_imm_start;
    @(posedge i_sys_clk) disable iff (!i_rst_b) s_acq_done_low |=> state_q == ST_CONV;
  endproperty
  a_imm_start: assert property (p_imm_start) else $error("start low did not convert");
  property p_wait_edge;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      i_ce && state_q == ST_WAIT_EDGE && !start_fall && !rst_s && !i_cfg.power_down_request
        |=> state_q == ST_WAIT_EDGE;
  endproperty
  a_wait_edge: assert property (p_wait_edge) else $error("left wait without edge");
  property p_busy;
    @(posedge i_sys_clk) disable iff (!i_rst_b) i_ce && $past(i_ce) && !rst_s |-> o_busy == ($past(state_q) == ST_CONV);
  endproperty
  a_busy: assert property (p_busy) else $error("busy mismatch");
  property p_reset_abort;
    @(posedge i_sys_clk) disable iff (!i_rst_b) i_ce && rst_s |=> state_q == ST_ACQ && !o_busy;
  endproperty
  a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");
  property p_pd_finish;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      i_ce && state_q == ST_CONV && cnt_q < CONV_CYC - 8'h01 && !rst_s |=> state_q == ST_CONV;
  endproperty
  a_pd_finish: assert property (p_pd_finish) else $error("conversion cut short");
  property p_oe_gate;
    @(posedge i_sys_clk) disable iff (!i_rst_b) o_data_oe[8] |-> $past(bus_en);
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("bus enabled without cs and rd");
  property p_err_slave;
    @(posedge i_sys_clk) disable iff (!i_rst_b) err_q |-> $past(slave) && $past(done_pulse_q);
  endproperty
  a_err_slave: assert property (p_err_slave) else $error("error outside slave read");
  property p_err_set;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      i_ce && done_pulse_q && !rst_s && slave && read_active_q && bits_left_q != 5'h00 |=> err_q;
  endproperty
  a_err_set: assert property (p_err_set) else $error("unfinished read gave no error");
  property p_high_oe;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      i_ce && $past(i_ce) |-> o_data_oe[15:`HIGH_LSB] == {4{$past(bus_en)}};
  endproperty
  a_high_oe: assert property (p_high_oe) else $error("top bits not driven as outputs");
  property p_shift_msb;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      i_ce && done_pulse_q && !rst_s |=> shreg_q[15] == $past(i_sar_result[15]);
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("msb not first");
endmodule

// ---- testbench/sar_host_model.sv ----
// Reading host: select, read strobe and slave serial clock
module sar_host_model (
  // Clock and data pins seen by the host
  input wire logic i_sys_clk,
  input wire logic [15:0] i_data,
  input wire logic [15:0] i_data_oe,
  input wire logic i_sclk,
  // Host control pins
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_sclk,
  // Finished read
  output logic o_valid,
  output logic [15:0] o_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] oe_seen;
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_sclk = 1'b0;
    o_valid = 1'b0;
    o_word = 16'h0000;
    oe_seen = 16'h0000;
  end
  task automatic select(input logic on);
    @(posedge i_sys_clk);
    #2;
    o_cs_n = !on;
    o_rd_n = !on;
  endtask
  task automatic done();
    @(posedge i_sys_clk);
    #2 o_valid = 1'b1;
    @(posedge i_sys_clk);
    #2 o_valid = 1'b0;
  endtask
  task automatic read_par();
    select(1'b1);
    repeat (8) @(posedge i_sys_clk);
    #2;
    oe_seen = i_data_oe;
    o_word = i_data;
    done();
    select(1'b0);
  endtask
  // Stray edges while deselected; clock stands still otherwise
  task automatic idle_clk();
    repeat (4) begin
      #160 o_sclk = 1'b1;
      #160 o_sclk = 1'b0;
    end
  endtask
  // Bit taken just before each rising edge, long after the last shift
  task automatic read_ser(input int n);
    select(1'b1);
    #320;
    repeat (n) begin
      o_word = {o_word[14:0], i_data[8]};
      o_sclk = 1'b1;
      #160 o_sclk = 1'b0;
      #160;
    end
    if (n == 16) done();
    select(1'b0);
  endtask
  // Master mode: bit taken when the device's clock is seen rising
  task automatic read_mst();
    int k;
    int n;
    logic prev;
    select(1'b1);
    prev = 1'b0;
    k = 0;
    n = 0;
    while (n < 16 && k < 400) begin
      @(posedge i_sys_clk);
      #2;
      if (i_sclk && !prev) begin
        o_word = {o_word[14:0], i_data[8]};
        n++;
      end
      prev = i_sclk;
      k++;
    end
    if (n == 16) done();
    select(1'b0);
  endtask
endmodule

// ---- testbench/sar_adc_conversion_control_tb_top.sv ----
// Bench for the converter control block
`include "sar_ctrl_consts.svh"
module sar_adc_conversion_control_tb_top
  import sar_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic dev_reset = 1'b0;
  logic start_n = 1'b0;
  mode_cfg_s cfg = '0;
  logic [15:0] sar_result = 16'h0000;
  logic busy, hold, pdn, sclk_m, sclk_oe, cs_n, rd_n, sclk, vld;
  logic [15:0] data, data_oe, word;
  // Released pins read as the inverse of the last value
  logic [15:0] pin_view;
  assign pin_view = (data & data_oe) | (~data & ~data_oe);
  logic [15:0] q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int n_flag = 0;
  int hi = 0;
  integer seed = 32'h9cf3;
  always #20 sys_clk = ~sys_clk;
  sar_adc_conversion_control u_sar_adc_conversion_control (
    .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_reset(dev_reset),
    .i_convert_start_n(start_n), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_cfg(cfg), .i_sclk(sclk),
    .i_sar_result(sar_result), .o_busy(busy), .o_hold(hold), .o_powered_down(pdn),
    .o_data(data), .o_data_oe(data_oe), .o_sclk(sclk_m), .o_sclk_oe(sclk_oe));
  sar_host_model u_sar_host_model (
    .i_sys_clk(sys_clk), .i_data(pin_view), .i_data_oe(data_oe), .i_sclk(sclk_m), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_sclk(sclk), .o_valid(vld), .o_word(word));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (busy !== lvl && k < lim) begin
      @(posedge sys_clk);
      #2;
      k++;
    end
    if (busy !== lvl) begin
      check("busy wait", 16'(busy), 16'(lvl));
      stop_test();
    end
  endtask
  task automatic conv(input logic edge_mode, input logic pd);
    int k;
    sar_result = 16'($random(seed));
    if (edge_mode) begin
      // Start high through acquisition for low jitter
      repeat (30) @(posedge sys_clk);
      #2;
      check("busy before edge", 16'(busy), 16'h0000);
    end
    start_n = 1'b0;
    wait_busy(1'b1, 60);
    start_n = 1'b1;
    cfg.power_down_request = pd;
    k = 0;
    while (busy === 1'b1 && k < 100) begin
      check("hold", 16'(hold), 16'h0001);
      @(posedge sys_clk);
      #2;
      k++;
    end
    check("busy length", 16'(k), 16'(`CONV_CYC));
  endtask
  // Oldest note is the value the host should have read
  always @(negedge sys_clk) begin
    if (data[11] === 1'b1 && cfg === mode_cfg_s'(3'b110)) n_flag++;
    if (vld === 1'b1 && q.size() > 0) check("read word", word, q.pop_front());
  end
  initial begin
    #3000000;
    check("timeout", 16'h0001, 16'h0000);
    stop_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #2 rst_b = 1'b1;
    check("busy after reset", 16'(busy), 16'h0000);
    check("oe after reset", data_oe, 16'h0000);
    conv(1'b0, 1'b0);
    q.push_back(sar_result);
    u_sar_host_model.read_par();
    check("parallel oe", u_sar_host_model.oe_seen, 16'hffff);
    repeat (8) @(posedge sys_clk);
    #2 check("idle oe", {4'h0, data_oe[11:0]}, 16'h0000);
    cfg = mode_cfg_s'(3'b110);
    conv(1'b1, 1'b0);
    u_sar_host_model.idle_clk();
    q.push_back(sar_result);
    u_sar_host_model.read_ser(16);
    check("sclk oe", 16'(sclk_oe), 16'h0000);
    check("no flag", 16'(n_flag), 16'h0000);
    conv(1'b1, 1'b0);
    u_sar_host_model.read_ser(8);
    conv(1'b1, 1'b0);
    q.push_back(sar_result);
    u_sar_host_model.read_ser(16);
    check("read error pulses", 16'(n_flag), 16'h0001);
    cfg = mode_cfg_s'(3'b100);
    conv(1'b1, 1'b0);
    q.push_back(sar_result);
    u_sar_host_model.read_mst();
    check("master sclk oe", 16'(sclk_oe), 16'h0001);
    check("no master flag", 16'(n_flag), 16'h0001);
    cfg = mode_cfg_s'(3'b000);
    conv(1'b1, 1'b1);
    start_n = 1'b0;
    repeat (80) begin
      @(posedge sys_clk);
      #2;
      if (busy !== 1'b0) hi++;
    end
    check("busy in power-down", 16'(hi), 16'h0000);
    check("powered down", 16'(pdn), 16'h0001);
    cfg.power_down_request = 1'b0;
    start_n = 1'b1;
    repeat (30) @(posedge sys_clk);
    #2 start_n = 1'b0;
    wait_busy(1'b1, 60);
    repeat (10) @(posedge sys_clk);
    #2 dev_reset = 1'b1;
    wait_busy(1'b0, 8);
    dev_reset = 1'b0;
    start_n = 1'b1;
    conv(1'b1, 1'b0);
    check("queue empty", 16'(q.size()), 16'h0000);
    stop_test();
  end
endmodule
